// ==== msp_host.sv ====
// msp_host: serial master model for the sensor port
// assumes: shares the system clock for its own timing only
`timescale 1ns/100ps
module msp_host (
   // system
   input wire logic clock,
   // serial pins
   output logic sclk,
   output logic mosi,
   output logic port_select_n,
   input wire logic miso
);
   int unstable = 0;
   initial begin
      sclk = 1'h1;
      mosi = 1'h0;
      port_select_n = 1'h1;
   end
   // frame edge; gaps kept short, port models no preparation delay
   task automatic sel(input logic on);
      @(negedge clock);
      port_select_n <= !on;
      if (!on) begin
         mosi <= !mosi;
      end
      repeat (6) @(negedge clock);
   endtask
   // n bits of one byte, msb first, mode 3
   task automatic xbyte(input logic [7:0] tx, input int n,
                        output logic [7:0] rx);
      logic b;
      rx = 8'h00;
      for (int i = 7; i > 7 - n; i--) begin
         @(negedge clock);
         sclk <= 1'h0;
         mosi <= tx[i];
         repeat (5) @(negedge clock);
         sclk <= 1'h1;
         b = miso;
         repeat (4) @(negedge clock);
         if (miso !== b) begin
            unstable++;
         end
         rx[i] = b;
      end
   endtask
   // clock and data toggling while deselected
   task automatic noise();
      for (int i = 0; i < 16; i++) begin
         @(negedge clock);
         sclk <= !sclk;
         mosi <= i[1];
         repeat (4) @(negedge clock);
      end
   endtask
endmodule // msp_host

// ==== msp_link_if.sv ====
// msp_link_if: synchronised link events between edge finder and port
// assumes: single clock domain
`timescale 1ns/100ps
interface msp_link_if;
   logic selected;
   logic rise;
   logic fall;
   logic mosi;
   modport source (output selected, output rise, output fall, output mosi);
   modport sink (input selected, input rise, input fall, input mosi);
endinterface

// ==== msp_pkg.sv ====
// msp_pkg: constants for the motion sensor serial port
// assumes: 125 MHz system clock, master-driven serial clock
package msp_pkg;
   localparam int unsigned clk_mhz = 125;
   localparam int unsigned byte_bits = 8;
   localparam logic [2:0] last_bit = 3'h7;
   localparam int unsigned dir_bit = 7;
   localparam logic dir_write = 1'h1;
   localparam int unsigned reg_count = 128;
   localparam logic [6:0] addr_motion = 7'h02;
   localparam logic [6:0] addr_dx_lo = 7'h03;
   localparam logic [6:0] addr_dx_hi = 7'h04;
   localparam logic [6:0] addr_dy_lo = 7'h05;
   localparam logic [6:0] addr_dy_hi = 7'h06;
   localparam logic [6:0] addr_burst = 7'h50;
   localparam logic [7:0] motion_flag_mask = 8'h80;
   localparam logic [3:0] all_deltas = 4'hF;
   localparam logic [7:0] reg_reset = 8'h00;
   typedef enum logic [1:0] {
      msp_idle_type_e, msp_addr, msp_data, msp_locked
   } msp_state_type;
endpackage

// ==== msp_port.sv ====
// msp_port: serial slave port with register array and motion pin
// assumes: master drives sclk, mosi, port_select_n; spi mode 3 timing
`timescale 1ns/100ps

// Notes on behaviour
// - only the master starts transfers
// - deselected: inputs ignored, output released
// - output fully released when not selected
// - transaction starts only after select low
// - select rise aborts; state and bit count return to idle
// - after burst, port refused until deselect
// - motion pin low while motion flag set
// - flag clears on all deltas read or motion register write
// - write: address byte msb 1, data byte
// - sample master data on rising clock
// - read: address msb 0, one data byte
// - change output bits on falling clock
// - hold output bit until next falling edge
module msp_port (
   // system
   input wire logic clock,
   input wire logic reset,
   // serial pins
   input wire logic sclk,
   input wire logic mosi,
   input wire logic port_select_n,
   output logic miso,
   output logic miso_oe,
   // motion
   input wire logic motion_event,
   output logic motion_n
);
   msp_link_if link ();
   msp_pkg::msp_state_type state;
   logic [7:0] shift_in;
   logic [7:0] shift_out;
   logic [2:0] bit_count;
   logic [6:0] address;
   logic is_write;
   logic [3:0] deltas_read;
   logic motion_flag;
   logic [7:0] regs [msp_pkg::reg_count];
   logic [7:0] next_byte;
   logic byte_done;
   logic clear_by_read;
   logic clear_by_write;
   logic dir_field;
   logic read_addr_done;
   logic read_bit;
   logic out_msb;

   msp_sync u_sync (
      .clock(clock),
      .reset(reset),
      .sclk(sclk),
      .mosi(mosi),
      .port_select_n(port_select_n),
      .link(link)
   );

   ////////////////////////////////////////////////////////////////////////
   // byte assembly
   assign next_byte = {shift_in[6:0], link.mosi};
   assign byte_done = link.rise && bit_count == msp_pkg::last_bit;

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         shift_in <= 8'h00;
         bit_count <= 3'h0;
      end else if (!link.selected) begin
         bit_count <= 3'h0;
      end else if (link.rise) begin
         shift_in <= next_byte;
         bit_count <= bit_count + 3'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // transaction state
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         state <= msp_pkg::msp_idle_type_e;
         address <= 7'h00;
         is_write <= 1'h0;
      end else if (!link.selected) begin
         state <= msp_pkg::msp_idle_type_e;
      end else begin
         case (state)
            msp_pkg::msp_idle_type_e: begin
               state <= msp_pkg::msp_addr;
            end
            msp_pkg::msp_addr: begin
               if (byte_done) begin
                  address <= next_byte[6:0];
                  is_write <= next_byte[msp_pkg::dir_bit]
                     == msp_pkg::dir_write;
                  state <= msp_pkg::msp_data;
               end
            end
            msp_pkg::msp_data: begin
               if (byte_done) begin
                  if (!is_write && address == msp_pkg::addr_burst) begin
                     state <= msp_pkg::msp_locked;
                  end else begin
                     state <= msp_pkg::msp_addr;
                  end
               end
            end
            msp_pkg::msp_locked: begin
               state <= msp_pkg::msp_locked;
            end
            default: begin
               state <= msp_pkg::msp_idle_type_e;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // register array
   always_ff @(posedge clock) begin
      if (state == msp_pkg::msp_data && is_write && byte_done) begin
         regs[address] <= next_byte;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read data output
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         shift_out <= 8'h00;
         miso <= 1'h0;
         miso_oe <= 1'h0;
      end else if (!link.selected) begin
         miso_oe <= 1'h0;
      end else if (state == msp_pkg::msp_addr && byte_done
                   && next_byte[msp_pkg::dir_bit] != msp_pkg::dir_write) begin
         shift_out <= (next_byte[6:0] == msp_pkg::addr_motion)
            ? (regs[next_byte[6:0]] | (motion_flag
               ? msp_pkg::motion_flag_mask : msp_pkg::reg_reset))
            : regs[next_byte[6:0]];
      end else if (link.fall) begin
         // only falling edges change the bit, held until the next one
         if (state == msp_pkg::msp_data && !is_write) begin
            miso <= shift_out[msp_pkg::dir_bit];
            shift_out <= {shift_out[6:0], 1'h0};
            miso_oe <= 1'h1;
         end else begin
            miso_oe <= 1'h0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // motion flag and pin
   assign clear_by_write = state == msp_pkg::msp_data && is_write
      && byte_done && address == msp_pkg::addr_motion;
   assign clear_by_read = deltas_read == msp_pkg::all_deltas;

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         deltas_read <= 4'h0;
      end else if (motion_event || clear_by_read) begin
         deltas_read <= 4'h0;
      end else if (state == msp_pkg::msp_addr && byte_done
                   && next_byte[msp_pkg::dir_bit] != msp_pkg::dir_write) begin
         case (next_byte[6:0])
            msp_pkg::addr_dx_lo: deltas_read[0] <= 1'h1;
            msp_pkg::addr_dx_hi: deltas_read[1] <= 1'h1;
            msp_pkg::addr_dy_lo: deltas_read[2] <= 1'h1;
            msp_pkg::addr_dy_hi: deltas_read[3] <= 1'h1;
            default: deltas_read <= deltas_read;
         endcase
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         motion_flag <= 1'h0;
         motion_n <= 1'h1;
      end else begin
         // a new event wins over a clear in the same cycle
         if (motion_event) begin
            motion_flag <= 1'h1;
         end else if (clear_by_read || clear_by_write) begin
            motion_flag <= 1'h0;
         end
         motion_n <= ~(motion_event
            | (motion_flag & ~(clear_by_read | clear_by_write)));
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // check helpers
   assign dir_field = next_byte[msp_pkg::dir_bit];
   assign read_addr_done = state == msp_pkg::msp_addr && byte_done
      && dir_field != msp_pkg::dir_write;
   assign read_bit = link.fall && state == msp_pkg::msp_data && !is_write;
   assign out_msb = shift_out[msp_pkg::dir_bit];

   ////////////////////////////////////////////////////////////////////////
   // checks
   a_release_deselect: assert property (@(posedge clock) disable iff (reset)
      !link.selected |=> !miso_oe)
      else $error("miso driven while deselected");
   a_release_full: assert property (@(posedge clock) disable iff (reset)
      $rose(port_select_n) |-> ##[1:4] !miso_oe)
      else $error("miso not released after deselect");
   a_abort_idle: assert property (@(posedge clock) disable iff (reset)
      !link.selected |=> state == msp_pkg::msp_idle_type_e
      && bit_count == 3'h0)
      else $error("port not reset on deselect");
   a_start_select: assert property (@(posedge clock) disable iff (reset)
      state == msp_pkg::msp_idle_type_e && !link.selected
      |=> state == msp_pkg::msp_idle_type_e)
      else $error("transaction began while deselected");
   a_burst_lock: assert property (@(posedge clock) disable iff (reset)
      state == msp_pkg::msp_locked && link.selected
      |=> state == msp_pkg::msp_locked)
      else $error("burst lock left while selected");
   a_motion_pin: assert property (@(posedge clock) disable iff (reset)
      motion_event |=> !motion_n)
      else $error("motion pin not lowered");
   a_motion_clear: assert property (@(posedge clock) disable iff (reset)
      clear_by_write && !motion_event |=> motion_n && !motion_flag)
      else $error("motion not cleared by write");
   a_miso_stable: assert property (@(posedge clock) disable iff (reset)
      !link.fall && link.selected && $past(link.selected) |=> $stable(miso))
      else $error("miso changed outside falling edge");
   a_sample_rise: assert property (@(posedge clock) disable iff (reset)
      link.rise |=> shift_in[0] == $past(link.mosi))
      else $error("mosi not sampled on rise");
   a_no_initiate: assert property (@(posedge clock)
      disable iff (reset) link.fall
      && !(state == msp_pkg::msp_data && !is_write) |=> !miso_oe)
      else $error("miso driven outside a read");
   a_ignore_inputs: assert property (@(posedge clock)
      disable iff (reset) !link.selected |=> $stable(shift_in))
      else $error("shift register moved while deselected");
   a_hold_address: assert property (@(posedge clock)
      disable iff (reset) !link.selected
      |=> $stable(address) && $stable(is_write))
      else $error("address moved while deselected");
   a_start_idle: assert property (@(posedge clock)
      disable iff (reset) state == msp_pkg::msp_idle_type_e
      && link.selected |=> state == msp_pkg::msp_addr)
      else $error("selected port did not wait for address");
   a_bit_count: assert property (@(posedge clock)
      disable iff (reset) link.rise
      |=> bit_count == $past(bit_count) + 3'h1)
      else $error("bit counter did not advance on rise");
   a_burst_enter: assert property (@(posedge clock)
      disable iff (reset) state == msp_pkg::msp_data && byte_done
      && !is_write && address == msp_pkg::addr_burst
      |=> state == msp_pkg::msp_locked)
      else $error("burst read did not lock the port");
   a_burst_quiet: assert property (@(posedge clock)
      disable iff (reset) state == msp_pkg::msp_locked && link.fall
      |=> !miso_oe)
      else $error("miso driven while locked");
   a_lock_no_load: assert property (@(posedge clock)
      disable iff (reset) state == msp_pkg::msp_locked
      |=> $stable(shift_out))
      else $error("read data loaded while locked");
   a_motion_hold: assert property (@(posedge clock)
      disable iff (reset) motion_flag && !clear_by_read && !clear_by_write
      |=> !motion_n)
      else $error("motion pin high while flag set");
   a_motion_bit: assert property (@(posedge clock)
      disable iff (reset) read_addr_done && motion_flag
      && next_byte[6:0] == msp_pkg::addr_motion |=> out_msb)
      else $error("motion register read without flag bit");
   a_set_wins: assert property (@(posedge clock)
      disable iff (reset) motion_event && (clear_by_read || clear_by_write)
      |=> motion_flag)
      else $error("clear won over a new motion event");
   a_motion_read_clr: assert property (@(posedge clock)
      disable iff (reset) clear_by_read && !motion_event
      |=> motion_n && !motion_flag)
      else $error("motion not cleared by delta reads");
   a_deltas_clear: assert property (@(posedge clock)
      disable iff (reset) motion_event |=> deltas_read == 4'h0)
      else $error("delta read record kept over new motion");
   a_write_lands: assert property (@(posedge clock)
      disable iff (reset) state == msp_pkg::msp_data && is_write
      && byte_done |=> regs[address] == $past(next_byte))
      else $error("write data not stored");
   a_dir_decode: assert property (@(posedge clock)
      disable iff (reset) state == msp_pkg::msp_addr && byte_done
      |=> is_write == ($past(dir_field) == msp_pkg::dir_write))
      else $error("direction bit not decoded");
   a_oe_on_read: assert property (@(posedge clock)
      disable iff (reset) read_bit |=> miso_oe)
      else $error("miso not driven during read data");
   a_miso_on_fall: assert property (@(posedge clock)
      disable iff (reset) $changed(miso) |-> $past(link.fall))
      else $error("miso changed away from a falling edge");
   a_msb_first: assert property (@(posedge clock)
      disable iff (reset) read_bit |=> miso == $past(out_msb))
      else $error("read bit not taken msb first");
endmodule // msp_port

// ==== msp_port_tb.sv ====
// msp_port_tb: self-checking bench for the sensor serial port
// assumes: msp_host plays the master on the serial pins
`timescale 1ns/100ps
module msp_port_tb;
   logic clock = 1'h0;
   logic reset;
   logic motion_event;
   logic sclk, mosi, port_select_n, miso, miso_oe, motion_n;
   wire logic miso_pin;
   int fails = 0;
   int checks = 0;
   logic [7:0] rx;
   always #4 clock = !clock;
   assign miso_pin = miso_oe ? miso : 1'hZ;
   msp_port u_msp_port (.clock(clock), .reset(reset), .sclk(sclk),
      .mosi(mosi), .port_select_n(port_select_n), .miso(miso),
      .miso_oe(miso_oe), .motion_event(motion_event),
      .motion_n(motion_n));
   msp_host u_msp_host (.clock(clock), .sclk(sclk), .mosi(mosi),
      .port_select_n(port_select_n), .miso(miso_pin));
   ////////////////////////////////////////////////////////////////////
   task automatic check(input string name, input logic [7:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] d, input int n);
      u_msp_host.sel(1'h1);
      u_msp_host.xbyte({1'h1, a}, 8, rx);
      u_msp_host.xbyte(d, n, rx);
      u_msp_host.sel(1'h0);
   endtask
   task automatic rd(input logic [6:0] a, output logic [7:0] d);
      u_msp_host.sel(1'h1);
      u_msp_host.xbyte({1'h0, a}, 8, rx);
      u_msp_host.xbyte(8'hFF, 8, d);
      check("miso_oe reading", {7'h00, miso_oe}, 8'h01);
      u_msp_host.sel(1'h0);
      check("miso_oe released", {7'h00, miso_oe}, 8'h00);
   endtask
   task automatic pulse();
      @(negedge clock);
      motion_event = 1'h1;
      @(negedge clock);
      motion_event = 1'h0;
      repeat (2) @(negedge clock);
   endtask
   ////////////////////////////////////////////////////////////////////
   task automatic t_rw();
      logic [7:0] d;
      check("motion_n reset", {7'h00, motion_n}, 8'h01);
      check("miso_oe reset", {7'h00, miso_oe}, 8'h00);
      wr(7'h10, 8'hA5, 8);
      wr(7'h11, 8'h3C, 8);
      rd(7'h10, d);
      check("reg 10", d, 8'hA5);
      rd(7'h11, d);
      check("reg 11", d, 8'h3C);
      check("miso hold", u_msp_host.unstable[7:0], 8'h00);
   endtask
   task automatic t_abort_noise();
      logic [7:0] d;
      wr(7'h11, 8'hC3, 4);
      rd(7'h11, d);
      check("aborted write", d, 8'h3C);
      u_msp_host.noise();
      check("miso_oe idle", {7'h00, miso_oe}, 8'h00);
      rd(7'h10, d);
      check("reg 10 after noise", d, 8'hA5);
   endtask
   task automatic t_motion();
      logic [7:0] d;
      wr(msp_pkg::addr_motion, 8'h00, 8);
      for (int i = 0; i < 4; i++) begin
         wr(msp_pkg::addr_dx_lo + i[6:0], 8'h40 + i[7:0], 8);
      end
      pulse();
      rd(msp_pkg::addr_motion, d);
      check("motion reg", d, msp_pkg::motion_flag_mask);
      for (int i = 0; i < 4; i++) begin
         check("motion_n held", {7'h00, motion_n}, 8'h00);
         rd(msp_pkg::addr_dx_lo + i[6:0], d);
         check("delta reg", d, 8'h40 + i[7:0]);
      end
      check("motion_n deltas read", {7'h00, motion_n}, 8'h01);
      pulse();
      check("motion_n set", {7'h00, motion_n}, 8'h00);
      wr(msp_pkg::addr_motion, 8'h00, 8);
      check("motion_n written", {7'h00, motion_n}, 8'h01);
   endtask
   task automatic t_burst();
      logic [7:0] d;
      wr(7'h12, 8'h5A, 8);
      wr(msp_pkg::addr_burst, 8'h77, 8);
      u_msp_host.sel(1'h1);
      u_msp_host.xbyte({1'h0, msp_pkg::addr_burst}, 8, d);
      u_msp_host.xbyte(8'hFF, 8, d);
      check("burst byte", d, 8'h77);
      u_msp_host.xbyte(8'h92, 8, d);
      u_msp_host.xbyte(8'hFF, 8, d);
      u_msp_host.sel(1'h0);
      rd(7'h12, d);
      check("locked write", d, 8'h5A);
   endtask
   ////////////////////////////////////////////////////////////////////
   task automatic end_of_test();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   initial begin
      reset = 1'h1;
      motion_event = 1'h0;
      repeat (4) @(posedge clock);
      @(negedge clock);
      reset = 1'h0;
      repeat (4) @(negedge clock);
      t_rw();
      t_abort_noise();
      t_motion();
      t_burst();
      end_of_test();
   end
   initial begin
      #100000;
      fails++;
      end_of_test();
   end
endmodule // msp_port_tb

// ==== msp_sync.sv ====
// msp_sync: two-flop synchronisers and serial clock edge finder
// assumes: pins are asynchronous to clock
`timescale 1ns/100ps
module msp_sync (
   // system
   input wire logic clock,
   input wire logic reset,
   // pins
   input wire logic sclk,
   input wire logic mosi,
   input wire logic port_select_n,
   // to port
   msp_link_if.source link
);
   logic [1:0] s_sclk;
   logic [1:0] s_mosi;
   logic [1:0] s_sel;
   logic sclk_old;

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         s_sclk <= 2'h3;
         s_mosi <= 2'h0;
         s_sel <= 2'h3;
         sclk_old <= 1'h1;
      end else begin
         s_sclk <= {s_sclk[0], sclk};
         s_mosi <= {s_mosi[0], mosi};
         s_sel <= {s_sel[0], port_select_n};
         sclk_old <= s_sclk[1];
      end
   end

   // edges only count while selected
   assign link.selected = ~s_sel[1];
   assign link.rise = s_sclk[1] & ~sclk_old & ~s_sel[1];
   assign link.fall = ~s_sclk[1] & sclk_old & ~s_sel[1];
   assign link.mosi = s_mosi[1];
endmodule // msp_sync
